/* File: hdl/logic_trigger_evaluator.v */
// Four-channel logic trigger evaluator with APB register access
// What this block does
// - Each channel has its own comparator output giving an independent variable.
// - Channel variable is true when input is above its threshold.
// - Trigger expression is an OR of AND terms.
// - At most two product terms per expression, ORed together.
// - Two separate product slots whose outputs are ORed.
// - Each product accepts any subset of the four channels.
// - Each included channel may be taken true or complemented.
// - Channels not included never affect the product, except the selected edge channel when edge is enabled.
// - A trigger pulse is produced when the expression is satisfied.
// - Each product may have one rising or falling edge channel.
// - Edge product true only at the selected transition with other terms met.
// - Nested mode: A true arms, then B true triggers.
// - Nested mode: B never triggers unless armed by A.
// - External reset high blocks trigger output and disarms nesting.
// - Two independent programs A and B.
// - Expression must stay true a programmable minimum before forwarding.
// - Optional external clock qualifies the trigger expression.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "trig_map.vh"
module logic_trigger_evaluator (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        input_channel_1,
	input  wire        input_channel_2,
	input  wire        input_channel_3,
	input  wire        input_channel_4,
	input  wire        external_clock,
	input  wire        external_reset,
	output reg         trigger_out,
	output reg         armed
);
	reg  [31:0] ctrl;
	reg  [31:0] prog_a0;
	reg  [31:0] prog_a1;
	reg  [31:0] prog_b0;
	reg  [31:0] prog_b1;
	reg  [15:0] filter_len;
	reg  [3:0]  sync1;
	reg  [3:0]  level;
	reg  [3:0]  prev_level;
	reg  [1:0]  ext_sync;
	reg         ext_rst_meta;
	reg         ext_rst;
	reg         ext_clk_prev;
	reg  [15:0] hold_cnt;
	reg         fn_prev;
	reg  [3:0]  pulse_cnt;
	reg         next_trigger;
	reg         next_armed;
	reg  [31:0] next_rdata;
	reg         next_err;
	wire        hit_a0;
	wire        hit_a1;
	wire        hit_b0;
	wire        hit_b1;
	wire        fn_a;
	wire        fn_b;
	wire [1:0]  mode;
	wire        qual_en;
	wire        sel_fn;
	wire        filtered;
	wire        ext_clk_rise;
	wire        qualified;
	wire        fire;
	wire        access;
	wire        wr;
	wire        setup;
	wire        nested;
	wire [2:0]  reg_sel;
	wire [31:0] status_word;

	// Register slots in the order of the address map
	localparam [2:0] SEL_CTRL    = 3'h0;
	localparam [2:0] SEL_PROG_A0 = 3'h1;
	localparam [2:0] SEL_PROG_A1 = 3'h2;
	localparam [2:0] SEL_PROG_B0 = 3'h3;
	localparam [2:0] SEL_PROG_B1 = 3'h4;
	localparam [2:0] SEL_FILTER  = 3'h5;
	localparam [2:0] SEL_STATUS  = 3'h6;
	localparam [2:0] SEL_NONE    = 3'h7;

	// Address decode shared by the write and read paths
	function [2:0] reg_index(input [11:0] addr);
		case (addr)
		`REG_CTRL:    reg_index = SEL_CTRL;
		`REG_PROG_A0: reg_index = SEL_PROG_A0;
		`REG_PROG_A1: reg_index = SEL_PROG_A1;
		`REG_PROG_B0: reg_index = SEL_PROG_B0;
		`REG_PROG_B1: reg_index = SEL_PROG_B1;
		`REG_FILTER:  reg_index = SEL_FILTER;
		`REG_STATUS:  reg_index = SEL_STATUS;
		default:      reg_index = SEL_NONE;
		endcase
	endfunction

	// Keep only the defined bits of a product term word
	function [31:0] term_word(input [31:0] w);
		term_word = w & `TERM_MASK;
	endfunction

	// Control fields, bus phases and address decode
	assign mode    = ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	assign qual_en = ctrl[`CTRL_QUAL_BIT];
	assign nested  = (mode == `MODE_A_THEN_B);
	assign access  = psel & penable;
	assign setup   = psel & ~penable;
	assign wr      = access & pwrite;
	assign reg_sel = reg_index(paddr);

	// Channel comparator outputs pass two flip-flops each
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1      <= 4'h0;
			level      <= 4'h0;
			prev_level <= 4'h0;
		end else begin
			sync1      <= {input_channel_4, input_channel_3,
				input_channel_2, input_channel_1};
			level      <= sync1;
			prev_level <= level;
		end
	end

	// External clock synchroniser and its previous sample for edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync     <= 2'h0;
			ext_clk_prev <= 1'b0;
		end else begin
			ext_sync     <= {ext_sync[0], external_clock};
			ext_clk_prev <= ext_sync[1];
		end
	end

	// External reset pin synchroniser
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_rst_meta <= 1'b0;
			ext_rst      <= 1'b0;
		end else begin
			ext_rst_meta <= external_reset;
			ext_rst      <= ext_rst_meta;
		end
	end

	// Two slots for each of the two independent programs
	product_term u_a0 (.cfg(prog_a0), .level(level), .prev_level(prev_level), .hit(hit_a0));
	product_term u_a1 (.cfg(prog_a1), .level(level), .prev_level(prev_level), .hit(hit_a1));
	product_term u_b0 (.cfg(prog_b0), .level(level), .prev_level(prev_level), .hit(hit_b0));
	product_term u_b1 (.cfg(prog_b1), .level(level), .prev_level(prev_level), .hit(hit_b1));

	// Sum of the two products per program
	assign fn_a = hit_a0 | hit_a1;
	assign fn_b = hit_b0 | hit_b1;

	// Function that drives the trigger path in the selected mode
	assign sel_fn = (mode == `MODE_A) ? fn_a : fn_b;

	// Minimum duration filter: true once held for filter_len cycles
	assign filtered = sel_fn & (hold_cnt >= filter_len);

	// Optional qualification on the rising edge of the external clock
	assign ext_clk_rise = ext_sync[1] & ~ext_clk_prev;
	assign qualified    = filtered & (~qual_en | ext_clk_rise);

	// Trigger on the rising edge of the qualified function
	assign fire = qualified & ~fn_prev;

	// Duration counter follows the selected function and saturates at its top
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= 16'h0000;
		end else if (!sel_fn) begin
			hold_cnt <= 16'h0000;
		end else if (hold_cnt != 16'hffff) begin
			hold_cnt <= hold_cnt + 16'h0001;
		end
	end

	// Last qualified value, so a held function fires once only, or once per external clock rise when qualification is on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fn_prev <= 1'b0;
		end else begin
			fn_prev <= qualified;
		end
	end

	// Arming and output pulse decisions
	always @* begin
		next_armed   = armed;
		next_trigger = 1'b0;
		if (ext_rst) begin
			next_armed = 1'b0;
		end else if (nested) begin
			if (armed && fire) begin
				next_trigger = 1'b1;
				next_armed   = 1'b0;
			end else if (fn_a) begin
				next_armed = 1'b1;
			end
		end else begin
			next_armed   = 1'b0;
			next_trigger = fire;
		end
	end

	// Armed state of the nested mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 1'b0;
		end else begin
			armed <= next_armed;
		end
	end

	// Trigger output register with fixed pulse length
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_out <= 1'b0;
			pulse_cnt   <= 4'h0;
		end else begin
			if (ext_rst) begin
				trigger_out <= 1'b0;
				pulse_cnt   <= 4'h0;
			end else if (next_trigger) begin
				trigger_out <= 1'b1;
				pulse_cnt   <= `PULSE_CYCLES - 4'h1;
			end else if (pulse_cnt != 4'h0) begin
				pulse_cnt <= pulse_cnt - 4'h1;
			end else begin
				trigger_out <= 1'b0;
			end
		end
	end

	// Register writes on the APB access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl       <= `CTRL_RESET;
			prog_a0    <= `TERM_RESET;
			prog_a1    <= `TERM_RESET;
			prog_b0    <= `TERM_RESET;
			prog_b1    <= `TERM_RESET;
			filter_len <= `FILTER_RESET;
		end else if (wr) begin
			case (reg_sel)
			SEL_CTRL:    ctrl       <= pwdata & `CTRL_MASK;
			SEL_PROG_A0: prog_a0    <= term_word(pwdata);
			SEL_PROG_A1: prog_a1    <= term_word(pwdata);
			SEL_PROG_B0: prog_b0    <= term_word(pwdata);
			SEL_PROG_B1: prog_b1    <= term_word(pwdata);
			SEL_FILTER:  filter_len <= pwdata[15:0];
			default:     ctrl       <= ctrl;
			endcase
		end
	end

	// Live status word: both functions, synchronised reset, armed state and levels
	assign status_word = {24'h000000, fn_b, fn_a, ext_rst, armed, level};

	// Read mux and error for unmapped addresses
	always @* begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		case (reg_sel)
		SEL_CTRL:    next_rdata = ctrl;
		SEL_PROG_A0: next_rdata = prog_a0;
		SEL_PROG_A1: next_rdata = prog_a1;
		SEL_PROG_B0: next_rdata = prog_b0;
		SEL_PROG_B1: next_rdata = prog_b1;
		SEL_FILTER:  next_rdata = {16'h0000, filter_len};
		SEL_STATUS:  next_rdata = status_word;
		default:     next_err   = 1'b1;
		endcase
		if (pwrite && reg_sel == SEL_STATUS)
			next_err = 1'b1;
	end

	// APB answer: no wait state, ready in the access phase's first cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & next_err;
			prdata  <= (setup & ~pwrite) ? next_rdata : 32'h00000000;
		end
	end
endmodule // logic_trigger_evaluator

/* File: pkg/trig_map.vh */
// Register offsets, field positions, reset values and timing counts of the trigger evaluator
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH

// Register byte addresses
`define REG_CTRL        12'h000
`define REG_PROG_A0     12'h004
`define REG_PROG_A1     12'h008
`define REG_PROG_B0     12'h00c
`define REG_PROG_B1     12'h010
`define REG_FILTER      12'h014
`define REG_STATUS      12'h018

// Control register fields
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_QUAL_BIT   2
`define MODE_A          2'h0
`define MODE_B          2'h1
`define MODE_A_THEN_B   2'h2

// Product term fields: include[3:0], polarity[11:8], edge enable 16, edge channel 18:17, rising 19
`define TERM_INC_LSB    0
`define TERM_POL_LSB    8
`define TERM_EDGE_BIT   16
`define TERM_ECH_LSB    17
`define TERM_RISE_BIT   19

// Reset values
`define CTRL_RESET      32'h00000000
`define TERM_RESET      32'h00000000
`define FILTER_RESET    16'h0000

// Writable bits of the control and product term words
`define CTRL_MASK       32'h00000007
`define TERM_MASK       32'h000f0f0f

// Trigger pulse length in cycles
`define PULSE_CYCLES    4'h1
`endif

/* File: hdl/product_term.v */
// One AND product over four channel variables with optional edge qualifier
`timescale 1ns/10ps
module product_term (
	input  wire [31:0] cfg,
	input  wire [3:0]  level,
	input  wire [3:0]  prev_level,
	output wire        hit
);
	wire [3:0] inc;
	wire [3:0] pol;
	wire       edge_en;
	wire [1:0] ech;
	wire       rise;
	wire [3:0] match;
	wire       now_v;
	wire       was_v;

	assign inc     = cfg[`TERM_INC_LSB+3:`TERM_INC_LSB];
	assign pol     = cfg[`TERM_POL_LSB+3:`TERM_POL_LSB];
	assign edge_en = cfg[`TERM_EDGE_BIT];
	assign ech     = cfg[`TERM_ECH_LSB+1:`TERM_ECH_LSB];
	assign rise    = cfg[`TERM_RISE_BIT];

	// Included channels must match their polarity; excluded ones always pass
	assign match = ~inc | ~(level ^ pol);
	assign now_v = level[ech];
	assign was_v = prev_level[ech];

	// Product true only when some channel is included, edge gated when enabled
	assign hit = (|inc) & (&match) &
		(~edge_en | (rise ? (now_v & ~was_v) : (~now_v & was_v)));
endmodule // product_term

/* File: verif/probe_circuit.sv */
// Model of the probed circuit that drives the four comparator outputs
`timescale 1ns/10ps
module probe_circuit (
	input  wire logic       pclk,
	input  wire logic [3:0] want,
	output logic            input_channel_1,
	output logic            input_channel_2,
	output logic            input_channel_3,
	output logic            input_channel_4
);
	// Start low so the block never sees an unknown level
	initial begin
		{input_channel_4, input_channel_3, input_channel_2, input_channel_1} = 4'h0;
	end

	// Levels move just after a clock edge, as a clocked circuit under test would
	always @(posedge pclk) begin
		{input_channel_4, input_channel_3, input_channel_2, input_channel_1} <= want;
	end
endmodule // probe_circuit

/* File: verif/trig_properties.sv */
// Timing checker for the register bus and trigger outputs
`timescale 1ns/10ps
module trig_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        external_reset,
	input wire logic        trigger_out,
	input wire logic        armed
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Steps of a bus request and of a held external reset
	sequence s_setup; psel && !penable; endsequence
	sequence s_rst_held; external_reset [*4]; endsequence

	property p_answer; s_setup |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("No answer after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("Answer longer than one cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("Error without answer");
	property p_rdz; !pready |-> prdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("Read data outside answer");
	property p_pulse; trigger_out |=> !trigger_out; endproperty
	a_pulse: assert property (p_pulse) else $error("Trigger pulse too long");
	property p_trig_blk; s_rst_held |-> !trigger_out; endproperty
	a_trig_blk: assert property (p_trig_blk) else $error("Trigger during reset");
	property p_arm_blk; s_rst_held |-> !armed; endproperty
	a_arm_blk: assert property (p_arm_blk) else $error("Armed during reset");
	property p_fire_clr; trigger_out && $past(armed) |-> !armed; endproperty
	a_fire_clr: assert property (p_fire_clr) else $error("Armed kept after fire");
endmodule // trig_checker

bind logic_trigger_evaluator trig_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.external_reset(external_reset), .trigger_out(trigger_out), .armed(armed));

/* File: verif/tb.sv */
// Self-checking bench of the logic trigger evaluator
`timescale 1ns/10ps
`include "trig_map.vh"
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        external_clock = 1'b0;
	logic        external_reset = 1'b0;
	logic [3:0]  want = 4'h0;
	logic [31:0] rd;
	logic        er;
	wire  [31:0] prdata;
	wire         pready, pslverr, trigger_out, armed;
	wire         input_channel_1, input_channel_2, input_channel_3, input_channel_4;
	int          bad_count = 0;
	int          num_checks = 0;

	// Free-running clock
	always #5 pclk = ~pclk;

	logic_trigger_evaluator dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .input_channel_1, .input_channel_2, .input_channel_3,
		.input_channel_4, .external_clock, .external_reset, .trigger_out, .armed);
	probe_circuit model (.pclk, .want, .input_channel_1, .input_channel_2, .input_channel_3,
		.input_channel_4);

	task chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// One bus transfer, held until the answer is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Set channel levels and count trigger pulses over ten cycles
	task drv(input logic [3:0] v, input int n);
		int c;
		c = 0;
		want <= v;
		repeat (10) begin
			@(posedge pclk);
			if (trigger_out === 1'b1) c++;
		end
		chk(c == n, "trigger count");
	endtask

	task t_regs;
		apb(1'b0, `REG_CTRL, 32'h0);
		chk(rd === `CTRL_RESET && er === 1'b0, "ctrl reset");
		apb(1'b1, `REG_PROG_A0, 32'h00000103);
		apb(1'b0, `REG_PROG_A0, 32'h0);
		chk(rd === 32'h00000103, "term readback");
		apb(1'b0, 12'h01c, 32'h0);
		chk(er === 1'b1 && rd === 32'h0, "unmapped");
		apb(1'b1, `REG_STATUS, 32'hff);
		chk(er === 1'b1, "status write");
	endtask

	task t_sop;
		logic [3:0] pv [6] = '{4'h1, 4'h3, 4'h5, 4'h8, 4'h2, 4'hf};
		int         pn [6] = '{1, 0, 1, 1, 0, 1};
		apb(1'b1, `REG_PROG_A1, 32'h00000808);
		apb(1'b1, `REG_CTRL, {30'h0, `MODE_A});
		for (int i = 0; i < 6; i++) begin
			drv(4'h0, 0);
			drv(pv[i], pn[i]);
		end
		apb(1'b1, `REG_CTRL, {30'h0, `MODE_B});
		drv(4'h1, 0);
	endtask

	task t_edge;
		apb(1'b1, `REG_PROG_B0, 32'h000b0303);
		drv(4'h3, 1);
		drv(4'h3, 0);
		drv(4'h1, 0);
	endtask

	task t_nest;
		apb(1'b1, `REG_PROG_A0, 32'h00000404);
		apb(1'b1, `REG_PROG_A1, 32'h0);
		apb(1'b1, `REG_CTRL, {30'h0, `MODE_A_THEN_B});
		drv(4'h3, 0);
		drv(4'h1, 0);
		drv(4'h5, 0);
		chk(armed === 1'b1, "arm by A");
		drv(4'h1, 0);
		drv(4'h3, 1);
		chk(armed === 1'b0, "disarm");
		external_reset <= 1'b1;
		drv(4'h5, 0);
		chk(armed === 1'b0, "held disarmed");
		drv(4'h7, 0);
		external_reset <= 1'b0;
		drv(4'h5, 0);
		chk(armed === 1'b1, "rearm");
	endtask

	task t_filt_qual;
		apb(1'b1, `REG_PROG_A0, 32'h00000101);
		apb(1'b1, `REG_CTRL, {30'h0, `MODE_A});
		apb(1'b1, `REG_FILTER, 32'h0000000e);
		drv(4'h0, 0);
		drv(4'h1, 0);
		drv(4'h1, 1);
		apb(1'b1, `REG_FILTER, 32'h0);
		apb(1'b1, `REG_CTRL, 32'h00000004);
		drv(4'h0, 0);
		drv(4'h1, 0);
		external_clock <= 1'b1;
		drv(4'h1, 1);
	endtask

	// Mode 3 as B, status word, external reset outside nested mode, reset mid-run
	task t_misc;
		apb(1'b1, `REG_CTRL, 32'h00000003);
		drv(4'h1, 0);
		drv(4'h3, 1);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd === 32'h00000043 && er === 1'b0, "status word");
		external_reset <= 1'b1;
		drv(4'h1, 0);
		drv(4'h3, 0);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd === 32'h00000063, "status in reset");
		external_reset <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `REG_PROG_B0, 32'h0);
		chk(rd === `TERM_RESET && trigger_out === 1'b0, "term after reset");
		apb(1'b0, `REG_CTRL, 32'h0);
		chk(rd === `CTRL_RESET && armed === 1'b0, "ctrl after reset");
	endtask

	task finish_test;
		$display("Checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_sop;
		t_edge;
		t_nest;
		t_filt_qual;
		t_misc;
		finish_test;
	end

	// Watchdog against a hang
	initial begin
		#100000;
		bad_count++;
		finish_test;
	end
endmodule // tb
